// ---- src/gate_enable_mode_control.sv ----
// Gate enable, dead time, fault clear and power mode control
// What this block does
// RULE_01: Each phase low-side command drives that phase's low-side gate.
// RULE_02: Each phase high-side command drives that phase's high-side gate.
// RULE_03: Gate outputs are active high; low turns the transistor off.
// RULE_04: Dead time comes from the host waveform or from the dead-time setting.
// RULE_05: Chip enable high turns on all functions and the gate outputs.
// RULE_06: Chip enable low leads to Standby or Sleep, never normal running.
// RULE_07: Standby turns off current amplifiers and the 12V regulator.
// RULE_08: Standby keeps buck, supervisor pin and monitoring running.
// RULE_09: Standby also turns off the 5V regulator.
// RULE_10: Chip enable low forces every gate output low at once.
// RULE_11: Low-power entry only after chip enable stays low 1 ms.
// RULE_12: Chip enable rising edge clears latched faults whose cause has gone.
// RULE_13: Sleep select set sends a qualified low into Sleep.
// RULE_14: Host holds chip enable low at least 250 us to wake.
// RULE_15: After the wake interval, next chip enable rise wakes from Sleep.
// RULE_16: Sleep select clear sends a qualified low into Standby.
// RULE_17: Low intervals are counted on the clock, restarted at each edge.
`timescale 1ns/1ps
module gate_enable_mode_control
  import gate_mode_pkg::*;
#(
  parameter int LOW_CYCLES = gate_mode_pkg::LOW_QUAL_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // PWM command pins
  input wire logic phaseALowCmd,
  input wire logic phaseBLowCmd,
  input wire logic phaseCLowCmd,
  input wire logic phaseAHighCmd,
  input wire logic phaseBHighCmd,
  input wire logic phaseCHighCmd,
  // Chip enable pin
  input wire logic chipEnable,
  // Configuration from the on-chip settings
  input wire logic [gate_mode_pkg::DT_CFG_W-1:0] deadTimeConfig,
  input wire logic sleepSelect,
  // Fault causes and supervisor from on-chip monitors
  input wire logic [gate_mode_pkg::FAULT_W-1:0] faultCause,
  input wire logic supervisorAlert,
  // Gate outputs
  output logic phaseALowGate,
  output logic phaseBLowGate,
  output logic phaseCLowGate,
  output logic phaseAHighGate,
  output logic phaseBHighGate,
  output logic phaseCHighGate,
  // Supervisor open-drain pin
  output logic supervisorAlertOut,
  output logic supervisorAlertOeN,
  // Function enables
  output logic currentAmpEn,
  output logic reg12vEn,
  output logic reg5vEn,
  output logic buckEn,
  output logic monitorEn,
  // Status
  output logic [gate_mode_pkg::FAULT_W-1:0] faultLatched,
  output logic inStandby,
  output logic inSleep
);
  import gate_mode_pkg::*;

  ce_timing_if ceIf ();

  logic [PIN_W-1:0] pinRaw;
  logic [PIN_W-1:0] pinSync;
  logic [PHASES-1:0] lowCmd;
  logic [PHASES-1:0] highCmd;
  logic [PHASES-1:0] lowGate_reg;
  logic [PHASES-1:0] highGate_reg;
  logic ceSync;
  logic ceLast_reg;
  logic ceRise;
  logic gateEnable;
  logic faultFree;
  logic wakeArmed_reg;
  logic [DT_CNT_W-1:0] deadCycles;
  power_mode_t mode_reg;
  power_mode_t mode_next;

  // Supplies and amplifiers stay up while active or still pending
  function automatic logic suppliesOn(input power_mode_t m);
    return (m == MODE_ACTIVE) || (m == MODE_LOW_PEND);
  endfunction

  // Only Sleep stops the buck and the monitors
  function automatic logic coreOn(input power_mode_t m);
    return m != MODE_SLEEP;
  endfunction

  // Raw pins: low commands, high commands, chip enable on top
  assign pinRaw = {chipEnable, phaseCHighCmd, phaseBHighCmd, phaseAHighCmd,
                   phaseCLowCmd, phaseBLowCmd, phaseALowCmd};

  // Every pin is asynchronous to clk, so all pass two flops
  pin_sync #(
    .W(PIN_W)
  ) uSync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pinRaw(pinRaw),
    .pinSync(pinSync)
  );

  // Command vectors indexed by phase
  assign lowCmd = pinSync[PHASES-1:0];
  assign highCmd = pinSync[2*PHASES-1:PHASES];
  assign ceSync = pinSync[PIN_CE];
  assign ceIf.ceLevel = ceSync;

  // One timer serves both the entry and the wake interval
  ce_low_timer #(
    .LOW_CYCLES(LOW_CYCLES)
  ) uTimer (
    .clk(clk),
    .sys_rst(sys_rst),
    .ceIf(ceIf)
  );

  // Previous synced level; resets low like the idle pin
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ceLast_reg <= 1'b0;
    end else begin
      ceLast_reg <= ceSync;
    end
  end

  assign ceRise = ceSync && !ceLast_reg;

  // Power mode sequence
  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      MODE_ACTIVE: begin
        if (!ceSync) begin
          mode_next = MODE_LOW_PEND; // see RULE_06
        end
      end
      MODE_LOW_PEND: begin
        if (ceSync) begin
          mode_next = MODE_ACTIVE; // see RULE_11
        end else if (ceIf.lowQualified) begin
          mode_next = sleepSelect ? MODE_SLEEP : MODE_STANDBY; // see RULE_13 see RULE_16
        end
      end
      MODE_STANDBY: begin
        if (ceRise) begin
          mode_next = MODE_ACTIVE; // see RULE_05
        end
      end
      MODE_SLEEP: begin
        if (ceRise && wakeArmed_reg) begin
          mode_next = MODE_ACTIVE; // see RULE_15
        end
      end
      default: begin
        mode_next = MODE_ACTIVE;
      end
    endcase
  end

  // Reset lands in active; synced chip enable then decides
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode_reg <= MODE_ACTIVE;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // Wake arming: a rise in Sleep wakes only once chip enable has been low for the wake interval
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wakeArmed_reg <= 1'b0;
    end else if (mode_reg != MODE_SLEEP || ceRise) begin
      wakeArmed_reg <= 1'b0;
    end else if (ceIf.wakeQualified) begin
      wakeArmed_reg <= 1'b1; // see RULE_14 see RULE_15
    end
  end

  // Fault latch; a cause still present survives the clearing edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      faultLatched <= FAULT_RESET;
    end else if (ceRise) begin
      faultLatched <= faultCause; // see RULE_12
    end else begin
      faultLatched <= faultLatched | faultCause;
    end
  end

  // Any latched fault holds every gate off until cleared
  assign faultFree = faultLatched == FAULT_RESET; // see RULE_12
  assign gateEnable = ceSync && (mode_reg == MODE_ACTIVE) && faultFree; // see RULE_05 see RULE_10

  // Code zero leaves the dead time to the host waveform
  assign deadCycles = DT_CNT_W'(int'(deadTimeConfig) * DEAD_TIME_STEP_CYCLES);

  // Per-phase gate drive with optional turn-on delay
  genvar p;
  generate
    for (p = 0; p < PHASES; p++) begin : gPhase
      logic [DT_CNT_W-1:0] lowHeld_reg;
      logic [DT_CNT_W-1:0] highHeld_reg;
      logic bothCmd;
      logic lowReq;
      logic highReq;

      // Both commands high is never passed on: shoot-through guard
      assign bothCmd = lowCmd[p] && highCmd[p];

      // Turn-on waits out the dead time, turn-off does not
      assign lowReq = gateEnable && lowCmd[p] && !bothCmd && (lowHeld_reg >= deadCycles); // see RULE_01
      assign highReq = gateEnable && highCmd[p] && !bothCmd && (highHeld_reg >= deadCycles); // see RULE_02

      always_ff @(posedge clk) begin
        if (sys_rst || !lowCmd[p]) begin
          lowHeld_reg <= DT_CNT_RESET;
        end else if (lowHeld_reg < deadCycles) begin
          lowHeld_reg <= lowHeld_reg + 8'h01; // see RULE_04
        end
      end

      always_ff @(posedge clk) begin
        if (sys_rst || !highCmd[p]) begin
          highHeld_reg <= DT_CNT_RESET;
        end else if (highHeld_reg < deadCycles) begin
          highHeld_reg <= highHeld_reg + 8'h01; // see RULE_04
        end
      end

      always_ff @(posedge clk) begin
        if (sys_rst) begin
          lowGate_reg[p] <= 1'b0;
        end else begin
          lowGate_reg[p] <= lowReq; // see RULE_01 see RULE_03
        end
      end

      always_ff @(posedge clk) begin
        if (sys_rst) begin
          highGate_reg[p] <= 1'b0;
        end else begin
          highGate_reg[p] <= highReq; // see RULE_02 see RULE_03
        end
      end
    end
  endgenerate

  // Outputs come straight from the gate flops
  assign phaseALowGate = lowGate_reg[0];
  assign phaseBLowGate = lowGate_reg[1];
  assign phaseCLowGate = lowGate_reg[2];
  assign phaseAHighGate = highGate_reg[0];
  assign phaseBHighGate = highGate_reg[1];
  assign phaseCHighGate = highGate_reg[2];

  // Function enables follow the mode; pending still counts as running
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      currentAmpEn <= 1'b0;
      reg12vEn <= 1'b0;
      reg5vEn <= 1'b0;
      buckEn <= 1'b0;
      monitorEn <= 1'b0;
    end else begin
      currentAmpEn <= suppliesOn(mode_next); // see RULE_07
      reg12vEn <= suppliesOn(mode_next); // see RULE_07
      reg5vEn <= suppliesOn(mode_next); // see RULE_09
      buckEn <= coreOn(mode_next); // see RULE_08
      monitorEn <= coreOn(mode_next); // see RULE_08
    end
  end

  // Status taken from the next mode so it lines up with the enables
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      inStandby <= 1'b0;
      inSleep <= 1'b0;
    end else begin
      inStandby <= mode_next == MODE_STANDBY; // see RULE_06
      inSleep <= mode_next == MODE_SLEEP; // see RULE_06
    end
  end

  // Supervisor pin pulls low on alert, also in Standby
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      supervisorAlertOut <= 1'b0;
      supervisorAlertOeN <= 1'b1;
    end else begin
      supervisorAlertOut <= 1'b0;
      supervisorAlertOeN <= !(supervisorAlert && coreOn(mode_reg)); // see RULE_08
    end
  end
endmodule // gate_enable_mode_control

// ---- src/gate_mode_pkg.sv ----
// Shared constants and types for the gate enable and power mode controller
package gate_mode_pkg;

  // Time base
  localparam int CLK_PERIOD_NS = 100;

  // Chip-enable low time before entering a low-power mode
  localparam int LOW_QUAL_MS = 1;
  localparam int LOW_QUAL_CYCLES = (LOW_QUAL_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Chip-enable low time that arms a wake from Sleep
  localparam int WAKE_LOW_US = 250;
  localparam int WAKE_LOW_CYCLES = (WAKE_LOW_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Dead-time step per code of the dead-time setting
  localparam int DEAD_TIME_STEP_NS = 100;
  localparam int DEAD_TIME_STEP_CYCLES = (DEAD_TIME_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Widths
  localparam int TIMER_W = 16;
  localparam int DT_CFG_W = 4;
  localparam int DT_CNT_W = 8;
  localparam int FAULT_W = 4;
  localparam int PIN_W = 7;
  localparam int PHASES = 3;

  // Bit positions in the synchronised pin vector
  localparam int PIN_CE = 6;

  // Reset values
  localparam logic [TIMER_W-1:0] TIMER_RESET = 16'h0000;
  localparam logic [DT_CNT_W-1:0] DT_CNT_RESET = 8'h00;
  localparam logic [FAULT_W-1:0] FAULT_RESET = 4'h0;

  // Power modes, Gray along active, pending, standby, sleep
  typedef enum logic [1:0] {
    MODE_ACTIVE = 2'h0,
    MODE_LOW_PEND = 2'h1,
    MODE_STANDBY = 2'h3,
    MODE_SLEEP = 2'h2
  } power_mode_t;

endpackage

// ---- src/ce_timing_if.sv ----
// Chip-enable level and qualification flags between core and low timer
`timescale 1ns/1ps
interface ce_timing_if;
  logic ceLevel;
  logic lowQualified;
  logic wakeQualified;

  modport core (output ceLevel, input lowQualified, input wakeQualified);
  modport timer (input ceLevel, output lowQualified, output wakeQualified);
endinterface

// ---- src/pin_sync.sv ----
// Two-stage synchroniser for the asynchronous input pins
`timescale 1ns/1ps
module pin_sync
  import gate_mode_pkg::*;
#(
  parameter int W = PIN_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Pins in, synchronised copy out
  input wire logic [W-1:0] pinRaw,
  output logic [W-1:0] pinSync
);
  logic [W-1:0] stage1_reg;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : gSync
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          stage1_reg[i] <= 1'b0;
          pinSync[i] <= 1'b0;
        end else begin
          stage1_reg[i] <= pinRaw[i];
          pinSync[i] <= stage1_reg[i];
        end
      end
    end
  endgenerate
endmodule // pin_sync

// ---- src/ce_low_timer.sv ----
// Measures how long chip enable has been low
`timescale 1ns/1ps
module ce_low_timer
  import gate_mode_pkg::*;
#(
  parameter int LOW_CYCLES = LOW_QUAL_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Level in, qualification flags out
  ce_timing_if.timer ceIf
);
  logic [TIMER_W-1:0] lowCount_reg;
  logic lastLevel_reg;
  logic edgeSeen;

  assign edgeSeen = ceIf.ceLevel != lastLevel_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lastLevel_reg <= 1'b0;
    end else begin
      lastLevel_reg <= ceIf.ceLevel;
    end
  end

  // Saturates so a long low never wraps back below the thresholds
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lowCount_reg <= TIMER_RESET;
    end else if (edgeSeen || ceIf.ceLevel) begin
      lowCount_reg <= TIMER_RESET; // see RULE_17
    end else if (lowCount_reg != {TIMER_W{1'b1}}) begin
      lowCount_reg <= lowCount_reg + 16'h0001; // see RULE_17
    end
  end

  assign ceIf.lowQualified = !ceIf.ceLevel && (lowCount_reg >= TIMER_W'(LOW_CYCLES - 1)); // see RULE_11
  assign ceIf.wakeQualified = !ceIf.ceLevel && (lowCount_reg >= TIMER_W'(WAKE_LOW_CYCLES - 1)); // see RULE_14
endmodule // ce_low_timer

// ---- verification/gate_enable_mode_control_props.sv ----
// Assertion checker for the gate enable and power mode controller
`timescale 1ns/1ps
module gate_enable_mode_control_props #(
  parameter int LOW_CYCLES = 3000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Pins and settings
  input wire logic phaseALowCmd,
  input wire logic phaseAHighCmd,
  input wire logic chipEnable,
  input wire logic [gate_mode_pkg::DT_CFG_W-1:0] deadTimeConfig,
  input wire logic sleepSelect,
  input wire logic [gate_mode_pkg::FAULT_W-1:0] faultCause,
  // Outputs
  input wire logic phaseALowGate,
  input wire logic phaseBLowGate,
  input wire logic phaseCLowGate,
  input wire logic phaseAHighGate,
  input wire logic phaseBHighGate,
  input wire logic phaseCHighGate,
  input wire logic currentAmpEn,
  input wire logic reg12vEn,
  input wire logic reg5vEn,
  input wire logic buckEn,
  input wire logic monitorEn,
  input wire logic [gate_mode_pkg::FAULT_W-1:0] faultLatched,
  input wire logic inStandby,
  input wire logic inSleep
);
  // Pin low time, counted raw, so sync latency shows as margin
  logic [15:0] lowCnt;
  always_ff @(posedge clk) begin
    if (sys_rst || chipEnable) begin
      lowCnt <= 16'h0000;
    end else if (lowCnt != 16'hFFFF) begin
      lowCnt <= lowCnt + 16'h0001;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_gates_ce_off: assert property ($fell(chipEnable) |-> ##3 ({phaseALowGate, phaseBLowGate, phaseCLowGate,
    phaseAHighGate, phaseBHighGate, phaseCHighGate} == 6'h00))
    else $error("gates on after chip enable fall");
  chk_low_cmd_follow: assert property ((chipEnable && phaseALowCmd && !phaseAHighCmd && deadTimeConfig == 4'h0
    && faultCause == 4'h0 && faultLatched == 4'h0)[*6] |-> phaseALowGate)
    else $error("low gate not following command");
  chk_standby_off: assert property (inStandby && $past(inStandby) |-> !currentAmpEn && !reg12vEn
    && !reg5vEn)
    else $error("standby left a supply on");
  chk_standby_keep: assert property (inStandby |-> buckEn && monitorEn)
    else $error("standby stopped buck or monitor");
  chk_entry_not_early: assert property ($rose(inStandby || inSleep) |-> lowCnt >= LOW_CYCLES)
    else $error("low power entry too early");
  chk_entry_not_late: assert property (lowCnt == LOW_CYCLES + 8 |-> inStandby || inSleep)
    else $error("low power entry missing");
  chk_mode_select: assert property ($rose(inStandby || inSleep) |-> inSleep == $past(sleepSelect))
    else $error("wrong low power mode");
  chk_sleep_wake: assert property (inSleep && $rose(chipEnable) |-> ##3 (!inSleep && currentAmpEn))
    else $error("no wake on chip enable rise");
endmodule // gate_enable_mode_control_props
bind gate_enable_mode_control gate_enable_mode_control_props #(.LOW_CYCLES(LOW_CYCLES)) i_props (.clk(clk),
  .sys_rst(sys_rst), .phaseALowCmd(phaseALowCmd), .phaseAHighCmd(phaseAHighCmd), .chipEnable(chipEnable),
  .deadTimeConfig(deadTimeConfig), .sleepSelect(sleepSelect), .faultCause(faultCause),
  .phaseALowGate(phaseALowGate), .phaseBLowGate(phaseBLowGate), .phaseCLowGate(phaseCLowGate),
  .phaseAHighGate(phaseAHighGate), .phaseBHighGate(phaseBHighGate), .phaseCHighGate(phaseCHighGate),
  .currentAmpEn(currentAmpEn), .reg12vEn(reg12vEn), .reg5vEn(reg5vEn), .buckEn(buckEn), .monitorEn(monitorEn),
  .faultLatched(faultLatched), .inStandby(inStandby), .inSleep(inSleep));

// ---- verification/host_model.sv ----
// Host controller model driving PWM commands and chip enable
`timescale 1ns/1ps
module host_model (
  // Clock
  input wire logic clk,
  // Pins toward the device
  output logic [2:0] lowCmd,
  output logic [2:0] highCmd,
  output logic chipEnable
);
  initial begin
    lowCmd = 3'h0;
    highCmd = 3'h0;
    chipEnable = 1'b0;
  end
  // Pins move on the falling edge, clear of sampling
  task automatic drive(input logic [2:0] lo, input logic [2:0] hi);
    @(negedge clk);
    lowCmd = lo;
    highCmd = hi;
  endtask
  // Caller times the low: short clears faults, long wakes
  task automatic setCe(input logic v);
    @(negedge clk);
    chipEnable = v;
  endtask
endmodule // host_model

// ---- verification/gate_enable_mode_control_test.sv ----
// Self-checking bench for the gate enable and power mode controller
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin failures++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module gate_enable_mode_control_test;
  import gate_mode_pkg::*;
  // Shortened low qualification, still above the wake count
  localparam int LOW_CYC = 3000;
  logic clk, sys_rst, chipEnable, sleepSelect, supervisorAlert, alertOut, alertOeN, inStandby, inSleep;
  logic [2:0] lowCmd, highCmd, lowGate, highGate;
  logic [4:0] en;
  logic [3:0] deadTimeConfig, faultCause, faultLatched;
  int failures = 0;
  int checks = 0;
  gate_enable_mode_control #(.LOW_CYCLES(LOW_CYC)) i_gate_enable_mode_control (.clk(clk), .sys_rst(sys_rst),
    .phaseALowCmd(lowCmd[0]), .phaseBLowCmd(lowCmd[1]), .phaseCLowCmd(lowCmd[2]),
    .phaseAHighCmd(highCmd[0]), .phaseBHighCmd(highCmd[1]), .phaseCHighCmd(highCmd[2]),
    .chipEnable(chipEnable), .deadTimeConfig(deadTimeConfig), .sleepSelect(sleepSelect),
    .faultCause(faultCause), .supervisorAlert(supervisorAlert),
    .phaseALowGate(lowGate[0]), .phaseBLowGate(lowGate[1]), .phaseCLowGate(lowGate[2]),
    .phaseAHighGate(highGate[0]), .phaseBHighGate(highGate[1]), .phaseCHighGate(highGate[2]),
    .supervisorAlertOut(alertOut), .supervisorAlertOeN(alertOeN), .currentAmpEn(en[4]), .reg12vEn(en[3]),
    .reg5vEn(en[2]), .buckEn(en[1]), .monitorEn(en[0]), .faultLatched(faultLatched),
    .inStandby(inStandby), .inSleep(inSleep));
  host_model i_host_model (.clk(clk), .lowCmd(lowCmd), .highCmd(highCmd), .chipEnable(chipEnable));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic conclude();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Sample after the edge so registered outputs have landed
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic testRoute();
    for (int i = 0; i < 3; i++) begin
      i_host_model.drive(3'b001 << i, 3'b000);
      cyc(5);
      `CHK("low gates", 3'b001 << i, lowGate)
      `CHK("high idle", 3'b000, highGate)
      i_host_model.drive(3'b000, 3'b001 << i);
      cyc(5);
      `CHK("high gates", 3'b001 << i, highGate)
    end
    i_host_model.drive(3'b111, 3'b111);
    cyc(5);
    `CHK("both commands", 6'h00, {lowGate, highGate})
    $display("route end");
  endtask
  task automatic testDead();
    // Low side of phase B at one code, high side of phase C at another
    for (int k = 0; k < 2; k++) begin
      @(negedge clk);
      deadTimeConfig = k ? 4'hA : 4'h5;
      i_host_model.drive(3'b000, 3'b000);
      cyc(4);
      i_host_model.drive(k ? 3'b000 : 3'b010, k ? 3'b100 : 3'b000);
      cyc(2 + deadTimeConfig);
      `CHK("inside dead time", 6'h00, {lowGate, highGate})
      cyc(1);
      `CHK("after dead time", k ? 6'h04 : 6'h10, {lowGate, highGate})
      i_host_model.drive(3'b000, 3'b000);
      cyc(3);
      `CHK("turn off", 6'h00, {lowGate, highGate})
    end
    @(negedge clk);
    deadTimeConfig = 4'h0;
    $display("dead time end");
  endtask
  task automatic testCeOff();
    i_host_model.drive(3'b111, 3'b000);
    cyc(5);
    `CHK("enables on", 5'h1F, en)
    i_host_model.setCe(1'b0);
    cyc(3);
    `CHK("gates off", 3'b000, lowGate)
    cyc(LOW_CYC - 20);
    `CHK("short low", 2'b00, {inStandby, inSleep})
    i_host_model.setCe(1'b1);
    cyc(5);
    `CHK("gates back", 3'b111, lowGate)
    $display("chip enable end");
  endtask
  task automatic toggle();
    i_host_model.setCe(1'b0);
    cyc(10);
    i_host_model.setCe(1'b1);
    cyc(5);
  endtask
  task automatic testFault();
    @(negedge clk);
    faultCause = 4'hF;
    cyc(2);
    @(negedge clk);
    faultCause = 4'h5;
    cyc(3);
    `CHK("latched", 4'hF, faultLatched)
    `CHK("held off", 3'b000, lowGate)
    toggle();
    `CHK("present kept", 4'h5, faultLatched)
    @(negedge clk);
    faultCause = 4'h0;
    toggle();
    `CHK("cleared", 4'h0, faultLatched)
    `CHK("gates after clear", 3'b111, lowGate)
    $display("fault end");
  endtask
  task automatic testMode(input logic sleep);
    int n;
    n = 0;
    @(negedge clk);
    sleepSelect = sleep;
    supervisorAlert = 1'b1;
    i_host_model.setCe(1'b0);
    while ((sleep ? inSleep : inStandby) !== 1'b1 && n < LOW_CYC + 50) begin
      cyc(1);
      n++;
    end
    if (n >= LOW_CYC + 50) begin
      failures++;
      return;
    end
    `CHK("entry time", LOW_CYC + 3, n)
    `CHK("other mode", 1'b0, sleep ? inStandby : inSleep)
    cyc(3);
    `CHK("low enables", sleep ? 5'h00 : 5'h03, en)
    `CHK("supervisor", sleep, alertOeN)
    `CHK("supervisor data", 1'b0, alertOut)
    i_host_model.setCe(1'b1);
    cyc(5);
    `CHK("woken", 7'h7C, {en, inStandby, inSleep})
    @(negedge clk);
    supervisorAlert = 1'b0;
    $display("mode end");
  endtask
  initial begin
    sys_rst = 1'b1;
    deadTimeConfig = 4'h0;
    sleepSelect = 1'b0;
    faultCause = 4'h0;
    supervisorAlert = 1'b0;
    repeat (20) @(posedge clk);
    @(negedge clk);
    `CHK("reset state", 19'h00002, {lowGate, highGate, en, faultLatched, inStandby, inSleep, alertOeN, alertOut})
    sys_rst = 1'b0;
    i_host_model.setCe(1'b1);
    cyc(5);
    testRoute();
    testDead();
    testCeOff();
    testFault();
    testMode(1'b0);
    testMode(1'b1);
    conclude();
  end
endmodule // gate_enable_mode_control_test
